// ===== verilog/atmc_pkg.sv
// Purpose: Constants, register map and carrier types of the converter trigger and mode control
// Assumes: Avalon-MM slave with 32-bit data, one aligned word per register
// Notes:   Byte address of each register is four times its index
package atmc_pkg;

   // ==========================================================================
   // Register map
   localparam logic [3:0] ATMC_IDX_DIS0    = 4'h1;
   localparam logic [3:0] ATMC_IDX_DIS1    = 4'h2;
   localparam logic [3:0] ATMC_IDX_CTLB    = 4'h3;
   localparam logic [3:0] ATMC_IDX_RES_LO  = 4'h4;
   localparam logic [3:0] ATMC_IDX_RES_HI  = 4'h5;
   localparam logic [3:0] ATMC_IDX_CONV    = 4'h6;
   localparam logic [3:0] ATMC_IDX_IRQ_ST  = 4'h7;
   localparam logic [3:0] ATMC_IDX_IRQ_EN  = 4'h8;
   localparam logic [3:0] ATMC_IDX_IRQ_CLR = 4'h9;

   // ==========================================================================
   // Field positions and masks
   localparam int         ATMC_B_BIPOLAR  = 7;
   localparam int         ATMC_B_ALTGAIN  = 6;
   localparam int         ATMC_B_REFHI    = 4;
   localparam int         ATMC_B_CHMSB    = 3;
   localparam logic [7:0] ATMC_CTLB_MASK  = 8'hdf;
   localparam logic [7:0] ATMC_DIS1_MASK  = 8'hf0;
   localparam int         ATMC_C_ENABLE   = 0;
   localparam int         ATMC_C_AUTO     = 1;
   localparam int         ATMC_C_LEFT     = 2;
   localparam int         ATMC_C_START    = 3;
   localparam int         ATMC_C_DONE     = 4;

   // ==========================================================================
   // Reset values
   localparam logic [7:0] ATMC_RST_REG    = 8'h00;
   localparam logic [2:0] ATMC_RST_IRQ    = 3'h0;

   // ==========================================================================
   // Trigger sources
   typedef enum logic [2:0] {
      ATMC_TRG_FREE  = 3'b000,
      ATMC_TRG_ACMP  = 3'b001,
      ATMC_TRG_EXT0  = 3'b010,
      ATMC_TRG_T0CA  = 3'b011,
      ATMC_TRG_T0OV  = 3'b100,
      ATMC_TRG_T0CB  = 3'b101,
      ATMC_TRG_T1OV  = 3'b110,
      ATMC_TRG_WDT   = 3'b111
   } atmc_trg_t;

   // Interrupt bits: 0 trigger start, 1 conversion done, 2 result overrun
   typedef struct packed {
      logic [9:0] code;
      logic       done;
   } atmc_core_res_t;

   typedef struct packed {
      logic       start;
      logic       bipolar;
      logic       alt_gain;
      logic       ref_hi;
      logic [5:0] channel;
   } atmc_core_cmd_t;

   typedef struct packed {
      logic [7:0]     dis0;
      logic [7:0]     dis1;
      logic [7:0]     ctlb;
      logic           conv_en;
      logic           auto_en;
      logic           left;
      logic           chan_msb;
      logic           trig_prev;
      logic           busy;
      logic           locked;
      logic [9:0]     result;
      logic [2:0]     irq_st;
      logic [2:0]     irq_en;
      logic           rd_pend;
      logic [31:0]    rdata;
      atmc_core_cmd_t cmd;
   } atmc_state_t;

endpackage : atmc_pkg

// ===== verilog/atmc_ctrl.sv
// Purpose: Trigger, mode, channel msb and pin buffer disable control of the converter
// Assumes: Core returns a one-cycle done pulse with a 10-bit code; flags synchronous
// Notes:   Waitrequest is low on writes and on the second cycle of a read
//
// Implementation choice: the Avalon-MM interface to the registers.
module atmc_ctrl
   import atmc_pkg::*;
#(
   parameter int PINS = 16
) (
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   input  wire logic [3:0]       avs_address_i,
   input  wire logic             avs_read_i,
   input  wire logic             avs_write_i,
   input  wire logic [31:0]      avs_writedata_i,
   input  wire logic [3:0]       avs_byteenable_i,
   output logic [31:0]           avs_readdata_o,
   output logic                  avs_waitrequest_o,
   input  wire logic [7:0]       periph_flags_i,
   input  wire logic [4:0]       channel_low_i,
   input  wire atmc_core_res_t   core_res_i,
   output atmc_core_cmd_t        core_cmd_o,
   input  wire logic [PINS-1:0]  pin_raw_i,
   output logic [PINS-1:0]       pin_value_o,
   output logic [PINS-1:0]       pin_buf_off_o,
   output logic                  irq_o
);

   initial begin
      if (PINS != 16) begin
         $error("atmc_ctrl: PINS must be 16");
      end
   end

   // ==========================================================================
   // Pin input synchroniser
   logic [PINS-1:0] pin_meta;
   logic [PINS-1:0] pin_sync;

   always_ff @(posedge clk_i) begin
      pin_meta <= pin_raw_i;
      pin_sync <= pin_meta;
   end

   // ==========================================================================
   // State
   atmc_state_t s;
   atmc_state_t next_s;

   logic       wr;
   logic       rd;
   logic       sel_flag;
   logic       trig_edge;
   logic [7:0] res_lo;
   logic [7:0] res_hi;
   logic [7:0] wb;
   logic [2:0] ev;

   always_comb begin
      wr = avs_write_i;
      rd = avs_read_i & ~s.rd_pend;
      wb = avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00;
      // Source zero never yields a level, so switching to it cannot trigger
      sel_flag = (s.ctlb[2:0] == ATMC_TRG_FREE) ? 1'b0 : periph_flags_i[s.ctlb[2:0]];
      // Mux output edge: a source switch to a set flag also rises
      trig_edge = s.auto_en & sel_flag & ~s.trig_prev;
      if (s.left) begin
         res_hi = s.result[9:2];
         res_lo = {s.result[1:0], 6'h00};
      end else begin
         res_hi = {6'h00, s.result[9:8]};
         res_lo = s.result[7:0];
      end
      ev = 3'h0;

      next_s = s;
      next_s.trig_prev = sel_flag;
      next_s.rd_pend = rd;
      next_s.cmd.start = 1'b0;

      if (wr && avs_byteenable_i[0]) begin
         unique case (avs_address_i)
            ATMC_IDX_DIS0: next_s.dis0 = wb;
            ATMC_IDX_DIS1: next_s.dis1 = wb & ATMC_DIS1_MASK;
            ATMC_IDX_CTLB: next_s.ctlb = wb & ATMC_CTLB_MASK;
            ATMC_IDX_CONV: begin
               next_s.conv_en = wb[ATMC_C_ENABLE];
               next_s.auto_en = wb[ATMC_C_AUTO];
               next_s.left    = wb[ATMC_C_LEFT];
               if (wb[ATMC_C_START] && wb[ATMC_C_ENABLE] && !s.busy) begin
                  next_s.cmd.start = 1'b1;
                  next_s.busy = 1'b1;
               end
            end
            ATMC_IDX_IRQ_EN:  next_s.irq_en = wb[2:0];
            ATMC_IDX_IRQ_CLR: next_s.irq_st = s.irq_st & ~wb[2:0];
            default: ;
         endcase
      end

      // Auto trigger start
      if (trig_edge && s.conv_en && !s.busy) begin
         next_s.cmd.start = 1'b1;
         next_s.busy = 1'b1;
         ev[0] = 1'b1;
      end

      // Conversion finished: latch result unless locked (then flag overrun), apply deferred channel msb
      if (core_res_i.done) begin
         next_s.busy = 1'b0;
         next_s.chan_msb = s.ctlb[ATMC_B_CHMSB];
         ev[1] = 1'b1;
         if (s.locked) begin
            ev[2] = 1'b1;
         end else begin
            next_s.result = core_res_i.code;
         end
      end

      // Low byte read locks the result until the high byte read
      if (rd && avs_address_i == ATMC_IDX_RES_LO) begin
         next_s.locked = 1'b1;
      end
      if (rd && avs_address_i == ATMC_IDX_RES_HI) begin
         next_s.locked = 1'b0;
      end

      // Free running restarts after each conversion
      if (core_res_i.done && s.auto_en && s.conv_en && s.ctlb[2:0] == ATMC_TRG_FREE) begin
         next_s.cmd.start = 1'b1;
         next_s.busy = 1'b1;
      end

      // Mode bits go straight to the core
      next_s.cmd.bipolar  = next_s.ctlb[ATMC_B_BIPOLAR];
      next_s.cmd.alt_gain = next_s.ctlb[ATMC_B_ALTGAIN];
      next_s.cmd.ref_hi   = next_s.ctlb[ATMC_B_REFHI];
      next_s.cmd.channel  = {next_s.chan_msb, channel_low_i};

      // Set wins over a simultaneous clear
      next_s.irq_st = next_s.irq_st | ev;

      if (rd) begin
         unique case (avs_address_i)
            ATMC_IDX_DIS0:   next_s.rdata = {24'h000000, s.dis0};
            ATMC_IDX_DIS1:   next_s.rdata = {24'h000000, s.dis1};
            ATMC_IDX_CTLB:   next_s.rdata = {24'h000000, s.ctlb};
            ATMC_IDX_RES_LO: next_s.rdata = {24'h000000, res_lo};
            ATMC_IDX_RES_HI: next_s.rdata = {24'h000000, res_hi};
            ATMC_IDX_CONV:   next_s.rdata = {27'h0000000, s.busy, 1'b0, s.left,
                                             s.auto_en, s.conv_en};
            ATMC_IDX_IRQ_ST: next_s.rdata = {29'h00000000, s.irq_st};
            ATMC_IDX_IRQ_EN: next_s.rdata = {29'h00000000, s.irq_en};
            default:         next_s.rdata = 32'h00000000;
         endcase
      end

      if (!nrst_i) begin
         next_s = '0;
         next_s.dis0   = ATMC_RST_REG;
         next_s.dis1   = ATMC_RST_REG;
         next_s.ctlb   = ATMC_RST_REG;
         next_s.irq_st = ATMC_RST_IRQ;
         next_s.irq_en = ATMC_RST_IRQ;
      end
   end

   always_ff @(posedge clk_i) begin
      s <= next_s;
   end

   // ==========================================================================
   // Outputs
   logic [PINS-1:0] off;

   // Pins 0..2 and 4..7 are analog 0..6, bit 3 the reference pin, 12..15 analog 7..10
   assign off = {s.dis1[7:4], 4'h0, s.dis0};

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pin_value_o   <= '0;
         pin_buf_off_o <= '0;
      end else begin
         pin_value_o   <= pin_sync & ~off;
         pin_buf_off_o <= off;
      end
   end

   assign avs_readdata_o    = s.rdata;
   assign avs_waitrequest_o = avs_read_i & ~s.rd_pend;
   assign core_cmd_o        = s.cmd;
   assign irq_o             = |(s.irq_st & s.irq_en);

endmodule : atmc_ctrl

// ===== dv/atmc_core_model.sv
// Purpose: Converter core stand-in
// Assumes: Start is a one-cycle pulse
// Notes:   Code is scrambled outside the done cycle
module atmc_core_model
   import atmc_pkg::*;
#(
   parameter logic [9:0] CODE = 10'h2a5
) (
   input  wire logic           clk_i,
   input  wire logic           nrst_i,
   input  wire atmc_core_cmd_t cmd_i,
   output atmc_core_res_t      res_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] cnt;
   // ==========
   // Five cycles from start to done; a start while busy is dropped
   always_ff @(posedge clk_i) begin
      res_o.code <= (cnt == 3'h1) ? CODE : ~CODE;
      res_o.done <= nrst_i && cnt == 3'h1;
      if (!nrst_i || cnt == 3'h0)
         cnt <= {cmd_i.start & nrst_i, 2'h0};
      else
         cnt <= cnt - 3'h1;
   end
endmodule : atmc_core_model

// ===== dv/atmc_ctrl_properties.sv
// Purpose: Port properties of the trigger and mode control
// Assumes: Sees only atmc_ctrl ports
// Notes:   Mode bits judged once control B is quiet
module atmc_ctrl_properties
   import atmc_pkg::*;
#(
   parameter int PINS = 16
) (
   input wire logic            clk_i,
   input wire logic            nrst_i,
   input wire logic [3:0]      avs_address_i,
   input wire logic            avs_read_i,
   input wire logic            avs_write_i,
   input wire logic [31:0]     avs_writedata_i,
   input wire logic [3:0]      avs_byteenable_i,
   input wire logic [31:0]     avs_readdata_o,
   input wire logic            avs_waitrequest_o,
   input wire atmc_core_res_t  core_res_i,
   input wire atmc_core_cmd_t  core_cmd_o,
   input wire logic [PINS-1:0] pin_value_o,
   input wire logic [PINS-1:0] pin_buf_off_o
);
   logic [7:0] ctlb_w;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   // ==========
   // Shadow of control B as last written
   always_ff @(posedge clk_i) begin
      if (!nrst_i)
         ctlb_w <= 8'h00;
      else if (avs_write_i && avs_byteenable_i[0] && avs_address_i == ATMC_IDX_CTLB)
         ctlb_w <= avs_writedata_i[7:0];
   end
   sequence rd_at_s(logic [3:0] idx);
      avs_read_i && !avs_waitrequest_o && avs_address_i == idx;
   endsequence
   sequence ctlb_calm_s;
      $stable(ctlb_w) [*2];
   endsequence
   write_no_wait_a: assert property (avs_write_i |-> !avs_waitrequest_o)
      else $error("write stalled");
   read_one_wait_a: assert property (avs_read_i && avs_waitrequest_o ##1 avs_read_i
      |-> !avs_waitrequest_o) else $error("read wait wrong");
   ctlb_res_zero_a: assert property (rd_at_s(ATMC_IDX_CTLB) |-> !avs_readdata_o[5])
      else $error("reserved bit set");
   dis1_res_zero_a: assert property (rd_at_s(ATMC_IDX_DIS1) |-> avs_readdata_o[3:0] == 4'h0)
      else $error("low nibble set");
   pin_masked_a: assert property ($stable(pin_buf_off_o) [*4]
      |-> (pin_value_o & pin_buf_off_o) == '0) else $error("disabled pin reads one");
   gap_pins_off_a: assert property (pin_buf_off_o[11:8] == 4'h0)
      else $error("unmapped disable set");
   mode_bits_a: assert property (ctlb_calm_s |-> {core_cmd_o.bipolar, core_cmd_o.alt_gain,
      core_cmd_o.ref_hi} == {ctlb_w[7], ctlb_w[6], ctlb_w[4]}) else $error("mode bits wrong");
   chan_msb_late_a: assert property ($changed(core_cmd_o.channel[5])
      |-> $past(core_res_i.done) || $past(core_res_i.done, 2)) else $error("msb moved early");
   rdata_hold_a: assert property (!avs_read_i |=> $stable(avs_readdata_o))
      else $error("read data moved");
endmodule : atmc_ctrl_properties
bind atmc_ctrl atmc_ctrl_properties #(.PINS(PINS)) atmc_ctrl_properties_inst (.clk_i, .nrst_i,
   .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
   .avs_readdata_o, .avs_waitrequest_o, .core_res_i, .core_cmd_o, .pin_value_o, .pin_buf_off_o);

// ===== dv/testbench.sv
// Purpose: Self-checking bench of the trigger and mode control
// Assumes: Core stand-in answers a start five cycles later
// Notes:   Trigger checks count start pulses after a fixed settle
module testbench
   import atmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic           clk_i = 1'h0;
   logic           nrst_i = 1'h0;
   logic [3:0]     avs_address_i = 4'h0;
   logic           avs_read_i = 1'h0;
   logic           avs_write_i = 1'h0;
   logic [31:0]    avs_writedata_i = 32'h0;
   logic [3:0]     avs_byteenable_i = 4'h1;
   logic [7:0]     periph_flags_i = 8'h00;
   logic [4:0]     channel_low_i = 5'h0a;
   logic [15:0]    pin_raw_i = 16'hffff;
   logic [31:0]    avs_readdata_o;
   logic           avs_waitrequest_o;
   atmc_core_res_t core_res_i;
   atmc_core_cmd_t core_cmd_o;
   logic [15:0]    pin_value_o;
   logic [15:0]    pin_buf_off_o;
   logic           irq_o;
   int             failures = 0;
   int             tests_run = 0;
   int             starts = 0;
   initial forever #5 clk_i = ~clk_i;
   atmc_ctrl atmc_ctrl_inst (.clk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .periph_flags_i,
      .channel_low_i, .core_res_i, .core_cmd_o, .pin_raw_i, .pin_value_o, .pin_buf_off_o, .irq_o);
   atmc_core_model atmc_core_model_inst (.clk_i, .nrst_i, .cmd_i(core_cmd_o), .res_o(core_res_i));
   always @(posedge clk_i)
      if (core_cmd_o.start === 1'h1)
         starts++;
   // ==========
   // Bus and compare helpers
   task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop
   task automatic bus(logic w, logic [3:0] a, logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_writedata_i <= {24'h0, d};
      // Waitrequest and read data are judged at the rising edge that takes the request
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'h0 && n < 50);
      q = avs_readdata_o[7:0];
      avs_write_i <= 1'h0;
      avs_read_i <= 1'h0;
      if (n >= 50) begin
         failures++;
         report_and_stop();
      end
   endtask : bus
   task automatic wr(logic [3:0] a, logic [7:0] d);
      logic [7:0] q;
      bus(1'h1, a, d, q);
   endtask : wr
   task automatic rd(string what, logic [3:0] a, logic [7:0] exp);
      logic [7:0] q;
      bus(1'h0, a, 8'h00, q);
      cmp(what, {8'h00, exp}, {8'h00, q});
   endtask : rd
   task automatic idle(int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask : idle
   task automatic t_regs();
      rd("ctlb", ATMC_IDX_CTLB, 8'h00);
      rd("dis1", ATMC_IDX_DIS1, 8'h00);
      rd("unmapped", 4'hf, 8'h00);
      wr(ATMC_IDX_CTLB, 8'hff);
      rd("ctlb", ATMC_IDX_CTLB, 8'hdf);
      idle(3);
      cmp("mode", {13'h0, core_cmd_o.bipolar, core_cmd_o.alt_gain, core_cmd_o.ref_hi}, 16'h7);
      wr(ATMC_IDX_DIS0, 8'h08);
      wr(ATMC_IDX_DIS1, 8'hff);
      rd("dis1", ATMC_IDX_DIS1, 8'hf0);
      idle(5);
      cmp("buf off", 16'hf008, pin_buf_off_o);
      cmp("pins", 16'h0ff7, pin_value_o);
      $display("registers and pins done");
   endtask : t_regs
   task automatic t_trig();
      wr(ATMC_IDX_CONV, 8'h01);
      wr(ATMC_IDX_CTLB, 8'h02);
      periph_flags_i <= 8'h04;
      idle(12);
      cmp("no auto", 16'h0, starts[15:0]);
      wr(ATMC_IDX_CONV, 8'h03);
      for (int c = 1; c < 8; c++) begin
         @(posedge clk_i);
         periph_flags_i <= 8'h00;
         wr(ATMC_IDX_CTLB, 8'h08 | 8'(c));
         periph_flags_i <= 8'h01 << c;
         idle(12);
         cmp("source", 16'(c), starts[15:0]);
      end
      rd("irq status", ATMC_IDX_IRQ_ST, 8'h03);
      wr(ATMC_IDX_IRQ_EN, 8'h02);
      idle(1);
      cmp("irq on", 16'h1, {15'h0, irq_o});
      wr(ATMC_IDX_IRQ_CLR, 8'h07);
      idle(1);
      cmp("irq off", 16'h0, {15'h0, irq_o});
      $display("trigger sources done");
   endtask : t_trig
   task automatic t_switch();
      wr(ATMC_IDX_CTLB, 8'h00);
      periph_flags_i <= 8'h20;
      wr(ATMC_IDX_CTLB, 8'h05);
      idle(12);
      cmp("switch edge", 16'h8, starts[15:0]);
      wr(ATMC_IDX_CTLB, 8'h00);
      periph_flags_i <= 8'hff;
      idle(12);
      cmp("free run switch", 16'h8, starts[15:0]);
      $display("source switching done");
   endtask : t_switch
   task automatic t_result();
      logic [7:0] q;
      wr(ATMC_IDX_CONV, 8'h09);
      idle(12);
      rd("low right", ATMC_IDX_RES_LO, 8'ha5);
      rd("high right", ATMC_IDX_RES_HI, 8'h02);
      wr(ATMC_IDX_CONV, 8'h0d);
      idle(12);
      rd("low left", ATMC_IDX_RES_LO, 8'h40);
      wr(ATMC_IDX_CONV, 8'h0d);
      idle(12);
      bus(1'h0, ATMC_IDX_IRQ_ST, 8'h00, q);
      cmp("overrun", 16'h1, {15'h0, q[2]});
      rd("high left", ATMC_IDX_RES_HI, 8'ha9);
      $display("result reads done");
   endtask : t_result
   initial begin
      repeat (3) @(posedge clk_i);
      nrst_i <= 1'h1;
      t_regs();
      t_trig();
      t_switch();
      t_result();
      report_and_stop();
   end
endmodule : testbench
